/* File: hdl/mb_pkg.sv */
// Shared constants and CRC helper for the query/response frame link.
// Assumes one 100 MHz clock; bytes on the link are already deserialised.
// Operation
// [R1] First frame byte is address, 1-247, 0 broadcast
// [R2] Broadcast queries are neither processed nor answered
// [R3] Only function codes 3, 4, 8, 16 accepted; the slave serves 3 and 4 only, others get exception 01
// [R4] Master sends even start address, high byte first; mb_master sends CMD_START as given, odd values included
// [R5] Master sends even register count, high byte first; mb_master sends CMD_COUNT as given, odd values included
// [R6] Frames end with check value, low byte first
// [R7] Reception errors discard the frame, no reply
// [R8] Each parameter is a 32-bit float, two registers
// [R9] Read reply: address, function, byte count, data, check
// [R10] Good reply echoes the query function code
// [R11] Faulty content with good check gets exception
// [R12] Exception function code is query code OR 80h
// [R13] Exception carries exactly one error code byte
// [R14] Code 04 returns input registers
// [R15] Code 03 returns holding registers
// [R16] Odd start or count gives error reply
// [R17] Float sent high register first, high byte first
// [R18] Check is CRC-16, poly A001, init FFFF
// [R19] Frames separated by 3.5 character idle gaps
package mb_pkg;
   // Address field
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [7:0] MAX_UNICAST = 8'hF7;
   // Function codes and exception marking
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INPUT = 8'h04;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
   // Error check
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;
   // Query layout: byte positions and lengths
   localparam logic [3:0] HDR_LEN = 4'h6;
   localparam logic [3:0] QUERY_LEN = 4'h8;
   localparam logic [3:0] MIN_FRAME = 4'h4;
   localparam logic [3:0] LEN_SAT = 4'hF;
   localparam int P_ADDR = 0;
   localparam int P_FC = 1;
   localparam int P_START_HI = 2;
   localparam int P_START_LO = 3;
   localparam int P_CNT_HI = 4;
   localparam int P_CNT_LO = 5;
   // Response layout
   localparam logic [5:0] RSP_HDR = 6'h03;
   localparam logic [5:0] IDX_ADDR = 6'h00;
   localparam logic [5:0] IDX_FC = 6'h01;
   localparam logic [5:0] IDX_CNT = 6'h02;
   localparam logic [15:0] MAX_REGS = 16'h000C;
   localparam logic [15:0] REG_PAIR = 16'h0002;
   // Response buffer shape: data byte plus last-byte flag
   localparam int FIFO_W = 9;
   localparam int FIFO_D = 32;
   // Gap: 3.5 characters of 11 bits at 9600 baud, rounded up
   localparam int CLK_PERIOD_NS = 10;
   localparam int CHAR_TIME_NS = 1146000;
   localparam int GAP_HALF_CHARS = 7;
   localparam int GAP_CYC = (CHAR_TIME_NS * GAP_HALF_CHARS + 2 * CLK_PERIOD_NS - 1)
                            / (2 * CLK_PERIOD_NS);
   // Master gives up on a reply after this long
   localparam int RSP_TMO_NS = 1000000;
   localparam int TMO_CYC = RSP_TMO_NS / CLK_PERIOD_NS;

   // One byte of the reflected CRC-16
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1); // [R18]
      end
      return c;
   endfunction
endpackage

/* File: hdl/mb_link_if.sv */
// Byte-level link between the bus master and the meter slave.
// Assumes both ends share CLK; the idle gap is signalled by q_end.
`timescale 1ns/1ns
interface mb_link_if;
   logic q_valid; // Query byte strobe
   logic [7:0] q_data; // Query byte
   logic q_perr; // Parity fault on this byte
   logic q_end; // Idle gap seen: frame complete
   logic r_valid; // Reply byte available
   logic [7:0] r_data; // Reply byte
   logic r_last; // Last byte of reply
   logic r_ready; // Master takes reply byte
   modport master (output q_valid, q_data, q_perr, q_end, r_ready,
                   input r_valid, r_data, r_last);
   modport slave (input q_valid, q_data, q_perr, q_end, r_ready,
                  output r_valid, r_data, r_last);
endinterface

/* File: hdl/mb_slave.sv */
// Meter end: response buffer, query checker and response builder.
// Assumes parameter values are served combinationally on REG_DATA.
`timescale 1ns/1ns

// Plain FIFO in flip-flops
module mb_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [W-1:0] IN_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [W-1:0] OUT_DATA
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem; // Storage
      logic [AW-1:0] wp; // Write index
      logic [AW-1:0] rp; // Read index
      logic [AW:0] cnt; // Fill level
   } fifo_t;
   fifo_t s_ff, nxt_s;
   logic push, pop;

   // Honest flags from the fill level
   assign IN_READY = (s_ff.cnt != (AW + 1)'(D));
   assign OUT_VALID = (s_ff.cnt != '0);
   assign OUT_DATA = s_ff.mem[s_ff.rp];
   assign push = IN_VALID && IN_READY;
   assign pop = OUT_VALID && OUT_READY;

   // Pointer and level update
   always_comb begin
      nxt_s = s_ff;
      if (push) begin
         nxt_s.mem[s_ff.wp] = IN_DATA;
         nxt_s.wp = (s_ff.wp == AW'(D - 1)) ? '0 : s_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_s.rp = (s_ff.rp == AW'(D - 1)) ? '0 : s_ff.rp + 1'b1;
      end
      nxt_s.cnt = s_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   // State register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule

module mb_slave (
   input wire logic CLK,
   input wire logic NRST,
   mb_link_if.slave LINK,
   input wire logic [7:0] MY_ADDR,
   output logic REG_RD,
   output logic REG_HOLD,
   output logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_DATA,
   output logic BUSY
);
   import mb_pkg::*;
   typedef enum logic [0:0] {S_RX = 1'b0, S_GEN = 1'b1} sst_t;
   typedef struct packed {
      sst_t st; // Receiving or building a reply
      logic [5:0][7:0] hdr; // First six query bytes
      logic [3:0] len; // Query length, saturating
      logic perr; // Parity fault seen in this frame
      logic [15:0] crc; // Running check, rx then tx
      logic [5:0] idx; // Reply byte index
      logic [5:0] total; // Reply length without check
      logic [7:0] exc; // Exception code, zero if none
   } slv_t;
   slv_t s_ff, nxt_s;
   logic f_valid, f_ready, f_last;
   logic [7:0] f_byte;
   logic [8:0] f_out;
   logic [15:0] q_start, q_cnt;
   logic [5:0] di;
   logic [7:0] chk_exc;
   logic frame_ok;

   assign q_start = {s_ff.hdr[P_START_HI], s_ff.hdr[P_START_LO]};
   assign q_cnt = {s_ff.hdr[P_CNT_HI], s_ff.hdr[P_CNT_LO]};
   assign di = s_ff.idx - RSP_HDR;

   // Content check, first fault in this order wins
   always_comb begin
      if (s_ff.hdr[P_FC] != FC_RD_HOLD && s_ff.hdr[P_FC] != FC_RD_INPUT) begin
         chk_exc = EXC_ILL_FUNC; // [R3] 8 and 16 are not served here
      end else if (s_ff.len != QUERY_LEN) begin
         chk_exc = EXC_ILL_VALUE; // [R11]
      end else if (q_start[0] || q_cnt[0]) begin
         chk_exc = EXC_ILL_ADDR; // [R16]
      end else if (q_cnt == '0 || q_cnt > MAX_REGS) begin
         chk_exc = EXC_ILL_VALUE; // [R11] reply must fit the buffer
      end else begin
         chk_exc = EXC_NONE;
      end
   end

   // Frame is for us and arrived clean
   assign frame_ok = !s_ff.perr && s_ff.len >= MIN_FRAME && s_ff.crc == CRC_GOOD // [R7]
                     && s_ff.hdr[P_ADDR] != BCAST_ADDR // [R2]
                     && s_ff.hdr[P_ADDR] == MY_ADDR; // [R1]

   // Register lookup: two registers per float, high half first
   assign REG_RD = (s_ff.st == S_GEN) && (s_ff.exc == EXC_NONE)
                   && (s_ff.idx >= RSP_HDR) && (s_ff.idx < s_ff.total);
   assign REG_HOLD = (s_ff.hdr[P_FC] == FC_RD_HOLD); // [R15]
   assign REG_ADDR = q_start + REG_PAIR * 16'(di[5:2]); // [R8] [R14]

   // Reply byte for the current index
   always_comb begin
      f_last = 1'b0;
      if (s_ff.idx == IDX_ADDR) begin
         f_byte = MY_ADDR; // [R9]
      end else if (s_ff.idx == IDX_FC) begin
         f_byte = (s_ff.exc == EXC_NONE) ? s_ff.hdr[P_FC] // [R10]
                                        : (s_ff.hdr[P_FC] | EXC_FLAG); // [R12]
      end else if (s_ff.idx == IDX_CNT) begin
         f_byte = (s_ff.exc == EXC_NONE) ? 8'(s_ff.total - RSP_HDR) : s_ff.exc; // [R9] [R13]
      end else if (s_ff.idx < s_ff.total) begin
         f_byte = REG_DATA[8 * (3 - int'(di[1:0])) +: 8]; // [R17]
      end else if (s_ff.idx == s_ff.total) begin
         f_byte = s_ff.crc[7:0]; // [R6]
      end else begin
         f_byte = s_ff.crc[15:8]; // [R6]
         f_last = 1'b1;
      end
   end
   assign f_valid = (s_ff.st == S_GEN);

   // Receive, check and build
   always_comb begin
      nxt_s = s_ff;
      case (s_ff.st)
         S_RX: begin
            if (LINK.q_valid) begin
               if (s_ff.len < HDR_LEN) begin
                  nxt_s.hdr[s_ff.len[2:0]] = LINK.q_data;
               end
               if (s_ff.len != LEN_SAT) begin
                  nxt_s.len = s_ff.len + 4'h1;
               end
               nxt_s.crc = crc_step(s_ff.crc, LINK.q_data); // [R18]
               nxt_s.perr = s_ff.perr | LINK.q_perr;
            end
            if (LINK.q_end) begin // [R19]
               nxt_s.len = '0;
               nxt_s.perr = 1'b0;
               nxt_s.crc = CRC_INIT;
               if (frame_ok) begin
                  nxt_s.st = S_GEN;
                  nxt_s.idx = '0;
                  nxt_s.exc = chk_exc;
                  nxt_s.total = (chk_exc == EXC_NONE) ? RSP_HDR + 6'(q_cnt[4:0]) * 6'h02
                                                      : RSP_HDR; // [R13]
               end
            end
         end
         S_GEN: begin
            // Stalls whenever the buffer is full
            if (f_ready) begin
               if (s_ff.idx < s_ff.total) begin
                  nxt_s.crc = crc_step(s_ff.crc, f_byte); // [R18]
               end
               nxt_s.idx = s_ff.idx + 6'h01;
               if (f_last) begin
                  nxt_s.st = S_RX;
                  nxt_s.crc = CRC_INIT;
               end
            end
         end
         default: begin
            nxt_s.st = S_RX;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_ff <= '{st: S_RX, crc: CRC_INIT, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Reply buffer between builder and link
   mb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .CLK(CLK),
      .NRST(NRST),
      .IN_VALID(f_valid),
      .IN_READY(f_ready),
      .IN_DATA({f_last, f_byte}),
      .OUT_VALID(LINK.r_valid),
      .OUT_READY(LINK.r_ready),
      .OUT_DATA(f_out)
   );
   assign LINK.r_data = f_out[7:0];
   assign LINK.r_last = f_out[8];
   // Queries arriving while a reply is built are dropped: link is half duplex
   assign BUSY = (s_ff.st == S_GEN);
endmodule

/* File: hdl/mb_master.sv */
// Bus master end: sends one read query, gap, then collects the reply.
// Assumes the slave end answers over the same link interface.
`timescale 1ns/1ns
module mb_master #(
   parameter int GAP_CYCLES = mb_pkg::GAP_CYC,
   parameter int TMO_CYCLES = mb_pkg::TMO_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   mb_link_if.master LINK,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic [7:0] CMD_ADDR,
   input wire logic [7:0] CMD_FC,
   input wire logic [15:0] CMD_START,
   input wire logic [15:0] CMD_COUNT,
   input wire logic CMD_BAD_CRC,
   input wire logic CMD_PERR,
   output logic RSP_VALID,
   output logic [7:0] RSP_BYTE,
   output logic RSP_LAST,
   output logic RSP_DONE,
   output logic RSP_CRC_OK,
   output logic RSP_TIMEOUT
);
   import mb_pkg::*;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00, M_SEND = 2'b01, M_GAP = 2'b10, M_WAIT = 2'b11
   } mst_t;
   typedef struct packed {
      mst_t st; // Sequencer state
      logic [5:0][7:0] frm; // Query body
      logic [3:0] idx; // Byte index being sent
      logic [15:0] crc; // Running check
      logic bad; // Corrupt the check value
      logic perr; // Flag a parity fault on one byte
      logic [31:0] cnt; // Gap and timeout counter
      logic q_valid, q_perr, q_end; // Link outputs
      logic [7:0] q_data;
      logic r_valid, r_last, done, crc_ok, tmo; // Reply outputs
      logic [7:0] r_byte;
   } mst_s_t;
   mst_s_t s_ff, nxt_s;
   logic [15:0] rx_crc;

   assign CMD_READY = (s_ff.st == M_IDLE);
   assign LINK.r_ready = (s_ff.st == M_WAIT);
   assign LINK.q_valid = s_ff.q_valid;
   assign LINK.q_data = s_ff.q_data;
   assign LINK.q_perr = s_ff.q_perr;
   assign LINK.q_end = s_ff.q_end;
   assign RSP_VALID = s_ff.r_valid;
   assign RSP_BYTE = s_ff.r_byte;
   assign RSP_LAST = s_ff.r_last;
   assign RSP_DONE = s_ff.done;
   assign RSP_CRC_OK = s_ff.crc_ok;
   assign RSP_TIMEOUT = s_ff.tmo;
   assign rx_crc = crc_step(s_ff.crc, LINK.r_data);

   // Query sequencer and reply collector
   always_comb begin
      nxt_s = s_ff;
      nxt_s.q_valid = 1'b0;
      nxt_s.q_perr = 1'b0;
      nxt_s.q_end = 1'b0;
      nxt_s.r_valid = 1'b0;
      nxt_s.r_last = 1'b0;
      nxt_s.done = 1'b0;
      case (s_ff.st)
         M_IDLE: begin
            if (CMD_VALID) begin
               // Address and function first, then fields high byte first
               nxt_s.frm[P_ADDR] = CMD_ADDR; // [R1]
               nxt_s.frm[P_FC] = CMD_FC;
               nxt_s.frm[P_START_HI] = CMD_START[15:8]; // [R4]
               nxt_s.frm[P_START_LO] = CMD_START[7:0]; // [R4]
               nxt_s.frm[P_CNT_HI] = CMD_COUNT[15:8]; // [R5]
               nxt_s.frm[P_CNT_LO] = CMD_COUNT[7:0]; // [R5]
               nxt_s.bad = CMD_BAD_CRC;
               nxt_s.perr = CMD_PERR;
               nxt_s.idx = '0;
               nxt_s.crc = CRC_INIT;
               nxt_s.st = M_SEND;
            end
         end
         M_SEND: begin
            nxt_s.q_valid = 1'b1;
            nxt_s.idx = s_ff.idx + 4'h1;
            if (s_ff.idx < HDR_LEN) begin
               nxt_s.q_data = s_ff.frm[s_ff.idx[2:0]];
               nxt_s.crc = crc_step(s_ff.crc, s_ff.frm[s_ff.idx[2:0]]); // [R18]
               nxt_s.q_perr = s_ff.perr && (s_ff.idx == 4'h0);
            end else if (s_ff.idx == HDR_LEN) begin
               nxt_s.q_data = s_ff.crc[7:0] ^ {7'h00, s_ff.bad}; // [R6]
            end else begin
               nxt_s.q_data = s_ff.crc[15:8]; // [R6]
               nxt_s.st = M_GAP;
               nxt_s.cnt = '0;
            end
         end
         M_GAP: begin
            // Hold the line idle before declaring the frame over
            nxt_s.cnt = s_ff.cnt + 32'h1;
            if (s_ff.cnt == 32'(GAP_CYCLES - 1)) begin
               nxt_s.q_end = 1'b1; // [R19]
               nxt_s.st = M_WAIT;
               nxt_s.cnt = '0;
               nxt_s.crc = CRC_INIT;
            end
         end
         M_WAIT: begin
            // No reply to broadcasts or damaged frames: timeout ends the wait
            nxt_s.cnt = s_ff.cnt + 32'h1;
            if (LINK.r_valid) begin
               nxt_s.r_valid = 1'b1;
               nxt_s.r_byte = LINK.r_data;
               nxt_s.r_last = LINK.r_last;
               nxt_s.crc = rx_crc; // [R18]
               if (LINK.r_last) begin
                  nxt_s.done = 1'b1;
                  nxt_s.crc_ok = (rx_crc == CRC_GOOD); // [R6]
                  nxt_s.tmo = 1'b0;
                  nxt_s.st = M_IDLE;
               end
            end else if (s_ff.cnt == 32'(TMO_CYCLES - 1)) begin
               nxt_s.done = 1'b1;
               nxt_s.crc_ok = 1'b0;
               nxt_s.tmo = 1'b1;
               nxt_s.st = M_IDLE;
            end
         end
         default: begin
            nxt_s.st = M_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_ff <= '{st: M_IDLE, crc: CRC_INIT, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule

/* File: tb/mb_link_assertions.sv */
// Concurrent checks on the byte link between the master and slave ends.
// Assumes one clock; the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module mb_link_assertions #(
   parameter int GAP_CYCLES = 4
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic q_valid,
   input wire logic [7:0] q_data,
   input wire logic q_perr,
   input wire logic q_end,
   input wire logic r_valid,
   input wire logic [7:0] r_data,
   input wire logic r_last,
   input wire logic r_ready
);
   import mb_pkg::*;
   localparam int GAP_M1 = GAP_CYCLES - 1; // Cycles from first idle cycle to q_end
   logic [3:0] qn_ff; // Query bytes seen since last q_end
   logic [7:0] qaddr_ff; // Address byte of query in flight
   logic [7:0] qfc_ff; // Function byte of query in flight
   logic perr_ff; // Parity fault seen in this query
   logic [7:0] ridx_ff; // Reply bytes taken so far
   logic [7:0] rcnt_ff; // Byte count field of the reply
   logic rexc_ff; // Reply is an exception
   logic [15:0] rcrc_ff; // Running check over reply bytes
   wire take = r_valid && r_ready; // Reply byte handed over

   // Frame trackers; q_end restarts both directions, as replies only follow it
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         qn_ff <= 4'h0;
         qaddr_ff <= 8'h00;
         qfc_ff <= 8'h00;
         perr_ff <= 1'b0;
         ridx_ff <= 8'h00;
         rcnt_ff <= 8'h00;
         rexc_ff <= 1'b0;
         rcrc_ff <= CRC_INIT;
      end else if (q_end) begin
         qn_ff <= 4'h0;
         perr_ff <= 1'b0;
         ridx_ff <= 8'h00;
         rcrc_ff <= CRC_INIT;
      end else begin
         if (q_valid) begin
            qn_ff <= qn_ff + 4'h1;
            qaddr_ff <= (qn_ff == 4'h0) ? q_data : qaddr_ff;
            qfc_ff <= (qn_ff == 4'h1) ? q_data : qfc_ff;
            perr_ff <= perr_ff | q_perr;
         end
         if (take) begin
            ridx_ff <= ridx_ff + 8'h01;
            rcrc_ff <= crc_step(rcrc_ff, r_data);
            rexc_ff <= (ridx_ff == 8'h01) ? r_data[7] : rexc_ff;
            rcnt_ff <= (ridx_ff == 8'h02) ? r_data : rcnt_ff;
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_query_eight_bytes: assert property (
      $rose(q_valid) |-> q_valid [*8] ##1 !q_valid) else $error("query not eight bytes");
   a_gap_then_end: assert property (
      $fell(q_valid) |-> !q_end ##GAP_M1 q_end) else $error("q_end not after gap");
   a_quiet_in_query: assert property (
      q_valid |-> !r_valid) else $error("reply overlaps query");
   a_drop_no_reply: assert property (
      q_end && (qaddr_ff == BCAST_ADDR || perr_ff) |=> !r_valid [*4])
      else $error("reply to dropped frame");
   a_reply_own_addr: assert property (
      take && ridx_ff == 8'h00 |-> r_data == qaddr_ff) else $error("reply address wrong");
   a_reply_func_code: assert property (
      take && ridx_ff == 8'h01 |-> r_data == qfc_ff || r_data == (qfc_ff | EXC_FLAG))
      else $error("reply function wrong");
   a_count_whole_floats: assert property (
      take && ridx_ff == 8'h02 && !rexc_ff |-> r_data[1:0] == 2'b00 && r_data != 8'h00)
      else $error("byte count not whole floats");
   a_exc_one_byte: assert property (
      take && r_last && rexc_ff |-> ridx_ff == 8'h04) else $error("exception length wrong");
   a_reply_length: assert property (
      take && r_last && !rexc_ff |-> ridx_ff == rcnt_ff + 8'h04) else $error("reply length wrong");
   a_reply_check: assert property (
      take && r_last |-> crc_step(rcrc_ff, r_data) == CRC_GOOD) else $error("reply check bad");
   a_byte_held: assert property (
      r_valid && !r_ready |=> r_valid && $stable(r_data)) else $error("reply byte dropped");

   c_normal: cover property (take && r_last && !rexc_ff);
   c_exception: cover property (take && r_last && rexc_ff);
   c_broadcast: cover property (q_end && qaddr_ff == BCAST_ADDR);
endmodule

/* File: tb/meter_modbus_slave_frames_test.sv */
// Self-checking bench: master and slave ends joined by the link interface.
// Assumes shortened gap and timeout counts so the run stays short.
`timescale 1ns/1ns
module meter_modbus_slave_frames_test;
   import mb_pkg::*;
   typedef logic [7:0] bq_t[$]; // Byte queue
   localparam int GAP = 4; // Shortened idle gap
   localparam int TMO = 200; // Shortened reply timeout
   logic clk = 1'b0;
   logic nrst = 1'b0; // Active low reset
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_fc = 8'h00;
   logic [15:0] cmd_start = 16'h0000;
   logic [15:0] cmd_count = 16'h0000;
   logic cmd_bad = 1'b0; // Corrupt the check value
   logic cmd_perr = 1'b0; // Parity fault on first byte
   logic [7:0] my_addr = 8'h01; // Slave own address
   logic cmd_ready, rsp_valid, rsp_last, rsp_done, rsp_ok, rsp_to, reg_rd, reg_hold, busy;
   logic [7:0] rsp_byte;
   logic [15:0] reg_addr;
   logic [31:0] reg_data;
   int n_fail = 0;
   int n_tests = 0;
   int tnum = 0;
   bq_t exp_q; // Expected reply
   bq_t got_q; // Reply seen

   always #5 clk = ~clk;

   // Register spaces differ so a swapped holding/input lookup shows
   function automatic logic [31:0] regval(input logic [15:0] a, input logic h);
      return {a ^ (h ? 16'hC35A : 16'h5AC3), ~a};
   endfunction
   assign reg_data = regval(reg_addr, reg_hold);

   // Reference check value, written independently of the design's helper
   function automatic logic [15:0] crc16(input bq_t q);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction

   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk1(input string what, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask

   // Expected reply; empty when the frame must be dropped
   task automatic build_exp(input logic [7:0] a, fc, input logic [15:0] st, cn);
      logic [7:0] ec;
      logic [15:0] c;
      logic [31:0] v;
      exp_q = {};
      if (cmd_bad || cmd_perr || a == BCAST_ADDR || a != my_addr) return;
      ec = EXC_NONE;
      if (cn == 16'h0000 || cn > MAX_REGS) ec = EXC_ILL_VALUE;
      if (st[0] || cn[0]) ec = EXC_ILL_ADDR;
      if (fc != FC_RD_HOLD && fc != FC_RD_INPUT) ec = EXC_ILL_FUNC;
      exp_q.push_back(a);
      if (ec != EXC_NONE) begin
         exp_q.push_back(fc | EXC_FLAG);
         exp_q.push_back(ec);
      end else begin
         exp_q.push_back(fc);
         exp_q.push_back(8'(cn * 16'h0002));
         for (int k = 0; k < int'(cn) / 2; k++) begin
            v = regval(st + 16'(2 * k), fc == FC_RD_HOLD);
            for (int j = 3; j >= 0; j--) exp_q.push_back(v[8 * j +: 8]);
         end
      end
      c = crc16(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
   endtask

   // One query through the master end, reply collected and judged
   task automatic run(input logic [7:0] a, fc, input logic [15:0] st, cn, input logic bad, pe);
      logic done;
      logic to;
      logic ok;
      logic [7:0] nexp;
      int nrd;
      int nbz;
      done = 1'b0;
      nrd = 0;
      nbz = 0;
      got_q = {};
      @(posedge clk);
      cmd_valid <= 1'b1;
      {cmd_addr, cmd_fc, cmd_start, cmd_count, cmd_bad, cmd_perr} <= {a, fc, st, cn, bad, pe};
      for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      cmd_valid <= 1'b0;
      build_exp(a, fc, st, cn);
      for (int i = 0; i < 1000 && !done; i++) begin
         @(posedge clk);
         // Slave pushes one reply byte per busy cycle; each lookup cycle serves one data byte
         nrd += int'(reg_rd === 1'b1);
         nbz += int'(busy === 1'b1);
         if (rsp_valid === 1'b1) begin
            got_q.push_back(rsp_byte);
            chk1("last", got_q.size() == exp_q.size(), rsp_last);
         end
         if (rsp_done === 1'b1) {done, to, ok} = {1'b1, rsp_to, rsp_ok};
      end
      chk1("done", 1'b1, done);
      chk1("timeout", exp_q.size() == 0, to);
      if (exp_q.size() != 0) chk1("crc ok", 1'b1, ok);
      chk8("length", 8'(exp_q.size()), 8'(got_q.size()));
      chk8("busy cycles", 8'(exp_q.size()), 8'(nbz));
      nexp = (exp_q.size() == 0 || exp_q[1][7]) ? 8'h00 : exp_q[2];
      chk8("lookups", nexp, 8'(nrd));
      foreach (exp_q[i]) begin
         chk8("reply byte", exp_q[i], i < got_q.size() ? got_q[i] : ~exp_q[i]);
      end
      $display("test %0d done", tnum++);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   mb_link_if mb_link_if_inst ();

   mb_master #(.GAP_CYCLES(GAP), .TMO_CYCLES(TMO)) mb_master_inst (.CLK(clk), .NRST(nrst),
      .LINK(mb_link_if_inst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
      .CMD_ADDR(cmd_addr), .CMD_FC(cmd_fc), .CMD_START(cmd_start), .CMD_COUNT(cmd_count),
      .CMD_BAD_CRC(cmd_bad), .CMD_PERR(cmd_perr), .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte),
      .RSP_LAST(rsp_last), .RSP_DONE(rsp_done), .RSP_CRC_OK(rsp_ok), .RSP_TIMEOUT(rsp_to));

   mb_slave mb_slave_inst (.CLK(clk), .NRST(nrst), .LINK(mb_link_if_inst), .MY_ADDR(my_addr),
      .REG_RD(reg_rd), .REG_HOLD(reg_hold), .REG_ADDR(reg_addr), .REG_DATA(reg_data),
      .BUSY(busy));

   mb_link_assertions #(.GAP_CYCLES(GAP)) mb_link_assertions_inst (.CLK(clk), .NRST(nrst),
      .q_valid(mb_link_if_inst.q_valid), .q_data(mb_link_if_inst.q_data),
      .q_perr(mb_link_if_inst.q_perr), .q_end(mb_link_if_inst.q_end),
      .r_valid(mb_link_if_inst.r_valid), .r_data(mb_link_if_inst.r_data),
      .r_last(mb_link_if_inst.r_last), .r_ready(mb_link_if_inst.r_ready));

   // Hang guard, well beyond the longest expected run
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      $display("BAD watchdog expected finish seen hang");
      end_sim();
   end

   initial begin
      logic [15:0] c;
      logic [7:0] m, fcs[4];
      fcs = '{FC_DIAG, FC_WR_MULTI, 8'h01, 8'h7F};
      void'($urandom(35806));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      c = crc16('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02});
      chk8("sample check lo", 8'h71, c[7:0]);
      run(8'h01, FC_RD_INPUT, 16'h0000, 16'h0002, 1'b0, 1'b0);
      run(8'h01, FC_RD_HOLD, 16'h000C, 16'h0004, 1'b0, 1'b0);
      run(8'h01, FC_RD_HOLD, 16'h0000, MAX_REGS, 1'b0, 1'b0);
      run(8'h01, FC_RD_INPUT, 16'h0000, 16'h000E, 1'b0, 1'b0);
      run(8'h01, FC_RD_INPUT, 16'h0000, 16'h0000, 1'b0, 1'b0);
      run(8'h01, FC_RD_INPUT, 16'h0001, 16'h0002, 1'b0, 1'b0);
      run(8'h01, FC_RD_HOLD, 16'h0002, 16'h0003, 1'b0, 1'b0);
      foreach (fcs[i]) run(8'h01, fcs[i], 16'h0000, 16'h0002, 1'b0, 1'b0);
      run(BCAST_ADDR, FC_RD_INPUT, 16'h0000, 16'h0002, 1'b0, 1'b0);
      run(8'h02, FC_RD_INPUT, 16'h0000, 16'h0002, 1'b0, 1'b0);
      run(8'h01, FC_RD_INPUT, 16'h0000, 16'h0002, 1'b1, 1'b0);
      run(8'h01, FC_RD_INPUT, 16'h0000, 16'h0002, 1'b0, 1'b1);
      my_addr <= MAX_UNICAST;
      run(MAX_UNICAST, FC_RD_HOLD, 16'h0010, 16'h0002, 1'b0, 1'b0);
      for (int t = 0; t < 30; t++) begin
         m = 8'(1 + $urandom % 247);
         my_addr <= m;
         run(($urandom % 4 == 0) ? 8'($urandom) : m,
             ($urandom % 3 == 0) ? 8'($urandom % 20) : (($urandom % 2) ? FC_RD_HOLD : FC_RD_INPUT),
             16'($urandom % 16), 16'($urandom % 16), 1'($urandom % 8 == 0),
             1'($urandom % 8 == 0));
      end
      end_sim();
   end
endmodule
